// *** testbench.sv ***
`timescale 1ns/100ps
module testbench;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, timer_tick = 0;
	logic global_irq_en = 0, ack_en = 0, pready, pslverr, wave_out_a, wave_out_b;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [2:0] irq_ack, irq_req;
	logic [3:0] lat = 4'h0;
	logic [7:0] v;
	logic [32:0] q[$];
	int num_errors = 0, n_compared = 0, i;
	tmc_timer i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_tick(timer_tick), .global_irq_en(global_irq_en), .irq_ack(irq_ack),
		.irq_req(irq_req), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b));
	tmc_cpu_model i_cpu (.clk(clk), .rst(rst), .ack_en(ack_en), .lat(lat), .irq_req(irq_req),
		.irq_ack(irq_ack));
	initial begin
		forever #2 clk = ~clk;
	end
	// ==========================================
	// shared tasks
	task summarize();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	task chk(input logic [32:0] s, input logic [32:0] e);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR t=%0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		n = 0;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		psel <= 0;
		penable <= 0;
		if (n == 50) begin
			num_errors++;
			summarize();
		end
	endtask : apb
	task rd(input logic [11:0] a, input logic [32:0] e);
		q.push_back(e);
		apb(0, a, 32'h0);
	endtask : rd
	task tk(input int n);
		repeat (n) @(posedge clk) timer_tick <= 1;
		@(posedge clk) timer_tick <= 0;
		repeat (3) @(posedge clk);
	endtask : tk
	// ==========================================
	// read monitor
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, q.pop_front());
	end
	// ==========================================
	// main sequence
	initial begin
		v = $urandom(32'hdbed6d15);
		v = 8'h04 + 8'($urandom % 112);
		repeat (12) @(posedge clk);
		rst <= 0;
		rd(tmc_pkg::ADDR_IRQ_MASK, 33'h0);
		rd(tmc_pkg::ADDR_IRQ_FLAGS, 33'h0);
		apb(1, tmc_pkg::ADDR_IRQ_MASK, 32'h6);
		rd(tmc_pkg::ADDR_IRQ_MASK, 33'h6);
		$display("test reset done");
		for (i = 0; i < 2; i++) begin
			apb(1, i ? tmc_pkg::ADDR_CMP_B : tmc_pkg::ADDR_CMP_A, {24'h0, v});
			apb(1, i ? tmc_pkg::ADDR_CMP_A : tmc_pkg::ADDR_CMP_B, {24'h0, v + 8'h40});
			apb(1, tmc_pkg::ADDR_COUNTER, {24'h0, v});
			tk(1);
			rd(tmc_pkg::ADDR_IRQ_FLAGS, 33'h0);
			apb(1, tmc_pkg::ADDR_COUNTER, {24'h0, v - 8'h2});
			tk(4);
			rd(tmc_pkg::ADDR_IRQ_FLAGS, 33'h1 << (i + 1));
			chk(i ? wave_out_b : wave_out_a, 33'h1);
			apb(1, tmc_pkg::ADDR_IRQ_FLAGS, 32'h0);
			rd(tmc_pkg::ADDR_IRQ_FLAGS, 33'h1 << (i + 1));
			apb(1, tmc_pkg::ADDR_IRQ_FLAGS, 32'h1 << (i + 1));
			rd(tmc_pkg::ADDR_IRQ_FLAGS, 33'h0);
			$display("test channel %0d done", i);
		end
		apb(1, tmc_pkg::ADDR_CTRL, 32'h1);
		repeat (3) @(posedge clk);
		chk(wave_out_a, 33'h0);
		rd(tmc_pkg::ADDR_IRQ_FLAGS, 33'h0);
		$display("test force done");
		global_irq_en <= 1;
		apb(1, tmc_pkg::ADDR_COUNTER, 32'hfe);
		tk(3);
		rd(tmc_pkg::ADDR_IRQ_FLAGS, 33'h1);
		chk(irq_req, 33'h0);
		apb(1, tmc_pkg::ADDR_IRQ_MASK, 32'h1);
		repeat (3) @(posedge clk);
		chk(irq_req, 33'h1);
		global_irq_en <= 0;
		repeat (3) @(posedge clk);
		chk(irq_req, 33'h0);
		global_irq_en <= 1;
		lat <= 4'($urandom % 8);
		ack_en <= 1;
		repeat (3) @(posedge clk);
		i = 0;
		while (irq_req !== 3'h0 && i < 40) begin
			@(posedge clk);
			i++;
		end
		chk(i < 40, 33'h1);
		rd(tmc_pkg::ADDR_IRQ_FLAGS, 33'h0);
		$display("test irq done");
		rd(12'hffc, 33'h1_0000_0000);
		$display("test unmapped done");
		summarize();
	end
endmodule : testbench

// *** tmc_cpu_model.sv ***
`timescale 1ns/100ps
// ==========================================
// cpu core: takes a pending vector after lat cycles
module tmc_cpu_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic ack_en,
	input wire logic [3:0] lat,
	input wire logic [2:0] irq_req,
	output logic [2:0] irq_ack
);
	logic [4:0] cnt;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 5'h00;
			irq_ack <= 3'h0;
		end else begin
			irq_ack <= 3'h0;
			if (!ack_en || irq_req == 3'h0) begin
				cnt <= 5'h00;
			end else if (cnt == {1'b0, lat}) begin
				irq_ack <= irq_req;
				cnt <= cnt + 5'h01;
			end else if (cnt < {1'b0, lat}) begin
				cnt <= cnt + 5'h01;
			end
		end
	end
endmodule : tmc_cpu_model

// *** tmc_match_unit.sv ***
`timescale 1ns/100ps
module tmc_match_unit #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic block,
	input wire logic force_strobe,
	input wire logic [W-1:0] count,
	input wire logic [W-1:0] compare,
	output logic match_event,
	output logic wave_out
);
	// ==========================================
	// comparator and toggle output
	wire logic hit = tick && !block && (count == compare);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			match_event <= 1'b0;
			wave_out <= 1'b0;
		end else begin
			match_event <= hit;
			if (hit || force_strobe) begin
				wave_out <= ~wave_out;
			end
		end
	end
endmodule : tmc_match_unit

// *** tmc_pkg.sv ***
package tmc_pkg;
	// ==========================================
	// register map (byte addresses)
	localparam logic [11:0] IDX_IRQ_MASK = 12'h06e;
	localparam logic [11:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK[9:0], 2'b00};
	localparam logic [11:0] ADDR_CMP_A = 12'h000;
	localparam logic [11:0] ADDR_CMP_B = 12'h004;
	localparam logic [11:0] ADDR_IRQ_FLAGS = 12'h008;
	localparam logic [11:0] ADDR_COUNTER = 12'h00c;
	localparam logic [11:0] ADDR_CTRL = 12'h010;
	localparam logic [11:0] ADDR_STATUS = 12'h014;
	// ==========================================
	// field positions and widths
	localparam int IRQ_W = 3;
	localparam int BIT_OVF = 0;
	localparam int BIT_MATCH_A = 1;
	localparam int BIT_MATCH_B = 2;
	localparam int CTRL_FORCE_A = 0;
	localparam int CTRL_FORCE_B = 1;
	localparam int CTRL_WAVE_LO = 2;
	localparam int CTRL_WAVE_HI = 4;
	localparam int CTRL_CLR_ON_MATCH = 5;
	localparam int STAT_OUT_A = 0;
	localparam int STAT_OUT_B = 1;
	localparam logic [2:0] IRQ_RESET = 3'h0;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	// ==========================================
	// grouped irq signals
	typedef struct packed {
		logic match_b;
		logic match_a;
		logic overflow;
	} tmc_irq_t;
endpackage : tmc_pkg

// *** tmc_timer.sv ***
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
// Notes on behaviour
// R1 - channel A compare checked each timer tick; match toggles output and raises event
// R2 - channel B compare checked each timer tick; match toggles output and raises event
// R3 - upper 29 bits of mask and flag registers read zero
// R4 - mask bit 2 gates channel B request together with global enable
// R5 - mask bit 1 gates channel A request together with global enable
// R6 - mask bit 0 gates overflow request together with global enable
// R7 - channel B match sets flag bit 2
// R8 - channel A match sets flag bit 1
// R9 - overflow sets flag bit 0; point depends on wave mode
// R10 - vector acknowledge clears matching flag
// R11 - writing one to a flag bit clears it
// R12 - request only when global enable, mask and flag all set
// R13 - forced strobe changes output only; no flag, no counter clear
// R14 - counter write suppresses compare on following tick
// R15 - writing zero leaves flag; flag writes never set
// R16 - all mask bits reset to zero
module tmc_timer #(
	parameter int CW = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer_tick,
	input wire logic global_irq_en,
	input wire logic [2:0] irq_ack,
	output logic [2:0] irq_req,
	output logic wave_out_a,
	output logic wave_out_b
);
	// ==========================================
	// bus decode
	wire logic wr = psel && penable && pwrite;
	wire logic sel_mask = (paddr == tmc_pkg::ADDR_IRQ_MASK);
	wire logic sel_cmp_a = (paddr == tmc_pkg::ADDR_CMP_A);
	wire logic sel_cmp_b = (paddr == tmc_pkg::ADDR_CMP_B);
	wire logic sel_flags = (paddr == tmc_pkg::ADDR_IRQ_FLAGS);
	wire logic sel_cnt = (paddr == tmc_pkg::ADDR_COUNTER);
	wire logic sel_ctrl = (paddr == tmc_pkg::ADDR_CTRL);
	wire logic sel_stat = (paddr == tmc_pkg::ADDR_STATUS);
	wire logic mapped = sel_mask | sel_cmp_a | sel_cmp_b | sel_flags | sel_cnt | sel_ctrl | sel_stat;
	// ==========================================
	// registers
	tmc_pkg::tmc_irq_t irq_mask;
	tmc_pkg::tmc_irq_t irq_flags;
	logic [CW-1:0] compare_value_a;
	logic [CW-1:0] compare_value_b;
	logic [CW-1:0] counter_value;
	logic [2:0] wave_mode_sel;
	logic clr_on_match;
	logic block_next;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_mask <= tmc_pkg::IRQ_RESET; // R16
			compare_value_a <= '0;
			compare_value_b <= '0;
			wave_mode_sel <= '0;
			clr_on_match <= 1'b0;
		end else if (wr) begin
			if (sel_mask) irq_mask <= pwdata[tmc_pkg::IRQ_W-1:0]; // R4 R5 R6
			if (sel_cmp_a) compare_value_a <= pwdata[CW-1:0];
			if (sel_cmp_b) compare_value_b <= pwdata[CW-1:0];
			if (sel_ctrl) begin
				wave_mode_sel <= pwdata[tmc_pkg::CTRL_WAVE_HI:tmc_pkg::CTRL_WAVE_LO];
				clr_on_match <= pwdata[tmc_pkg::CTRL_CLR_ON_MATCH];
			end
		end
	end
	// ==========================================
	// force strobes, write-only pulses
	wire logic force_a = wr && sel_ctrl && pwdata[tmc_pkg::CTRL_FORCE_A];
	wire logic force_b = wr && sel_ctrl && pwdata[tmc_pkg::CTRL_FORCE_B];
	wire logic cnt_wr = wr && sel_cnt;
	// ==========================================
	// match units
	logic ev_a;
	logic ev_b;
	logic out_a;
	logic out_b;
	tmc_match_unit #(.W(CW)) u_a (
		.clk(clk),
		.rst(rst),
		.tick(timer_tick),
		.block(block_next),
		.force_strobe(force_a),
		.count(counter_value),
		.compare(compare_value_a),
		.match_event(ev_a),
		.wave_out(out_a)
	); // R1 R13 R14
	tmc_match_unit #(.W(CW)) u_b (
		.clk(clk),
		.rst(rst),
		.tick(timer_tick),
		.block(block_next),
		.force_strobe(force_b),
		.count(counter_value),
		.compare(compare_value_b),
		.match_event(ev_b),
		.wave_out(out_b)
	); // R2 R13 R14
	assign wave_out_a = out_a;
	assign wave_out_b = out_b;
	// ==========================================
	// counter, for match and overflow events and read back at ADDR_COUNTER
	wire logic ctc_hit = clr_on_match && !block_next && (counter_value == compare_value_a);
	wire logic [CW-1:0] top = clr_on_match ? compare_value_a : tmc_pkg::COUNT_MAX;
	wire logic wrap = timer_tick && (counter_value == top);
	wire logic ovf_at_max = timer_tick && (counter_value == tmc_pkg::COUNT_MAX);
	wire logic ovf_ev = (wave_mode_sel[0] && !wave_mode_sel[1]) ?
		(timer_tick && counter_value == tmc_pkg::COUNT_BOTTOM) : ovf_at_max; // R9
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			counter_value <= tmc_pkg::BYTE_RESET;
			block_next <= 1'b0;
		end else if (cnt_wr) begin
			counter_value <= pwdata[CW-1:0];
			block_next <= 1'b1; // R14
		end else if (timer_tick) begin
			block_next <= 1'b0;
			counter_value <= (wrap || (ctc_hit && timer_tick)) ? '0 : counter_value + 1'b1;
		end
	end
	// ==========================================
	// flags: set wins over clear
	wire tmc_pkg::tmc_irq_t sets = {ev_b, ev_a, ovf_ev}; // R7 R8 R9
	wire tmc_pkg::tmc_irq_t sw_clr = (wr && sel_flags) ? pwdata[2:0] : 3'h0; // R11 R15
	wire tmc_pkg::tmc_irq_t next_flags = sets | (irq_flags & ~sw_clr & ~irq_ack); // R10
	always_ff @(posedge clk or posedge rst) begin
		if (rst) irq_flags <= tmc_pkg::IRQ_RESET;
		else irq_flags <= next_flags;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) irq_req <= 3'h0;
		else irq_req <= global_irq_en ? (next_flags & irq_mask) : 3'h0; // R12
	end
	// ==========================================
	// apb read and answer
	wire logic [31:0] rmux =
		sel_mask ? {29'h0, irq_mask} : // R3
		sel_flags ? {29'h0, irq_flags} : // R3
		sel_cmp_a ? {24'h0, compare_value_a} :
		sel_cmp_b ? {24'h0, compare_value_b} :
		sel_cnt ? {24'h0, counter_value} :
		sel_ctrl ? {26'h0, clr_on_match, wave_mode_sel, 2'h0} :
		sel_stat ? {30'h0, out_b, out_a} : 32'h0;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= (psel && !penable) ? rmux : 32'h0;
		end
	end
	// ==========================================
	// checks
	property p_req_gate;
		@(posedge clk) disable iff (rst) irq_req[2] |-> $past(irq_mask[2]) && $past(global_irq_en);
	endproperty
	a_req_gate: assert property (p_req_gate) else $error("req without enable"); // R4
	property p_req_a;
		@(posedge clk) disable iff (rst) irq_req[1] |-> $past(irq_mask[1]);
	endproperty
	a_req_a: assert property (p_req_a) else $error("req a without mask"); // R5
	property p_req_o;
		@(posedge clk) disable iff (rst) irq_req[0] |-> $past(irq_mask[0]);
	endproperty
	a_req_o: assert property (p_req_o) else $error("overflow req without mask"); // R6
	property p_set_b;
		@(posedge clk) disable iff (rst) ev_b |=> irq_flags[2];
	endproperty
	a_set_b: assert property (p_set_b) else $error("flag b not set"); // R7
	property p_set_a;
		@(posedge clk) disable iff (rst) ev_a |=> irq_flags[1];
	endproperty
	a_set_a: assert property (p_set_a) else $error("flag a not set"); // R8
	property p_clr;
		@(posedge clk) disable iff (rst) (wr && sel_flags && pwdata[1] && !ev_a) |=> !irq_flags[1];
	endproperty
	a_clr: assert property (p_clr) else $error("flag not cleared"); // R11
	property p_noset;
		@(posedge clk) disable iff (rst) (!irq_flags[1] && !ev_a) |=> !irq_flags[1];
	endproperty
	a_noset: assert property (p_noset) else $error("flag set by write"); // R15
	property p_block;
		@(posedge clk) disable iff (rst) cnt_wr |=> ##1 (!ev_a && !ev_b);
	endproperty
	a_block: assert property (p_block) else $error("match after counter write"); // R14
	property p_ack;
		@(posedge clk) disable iff (rst) (irq_ack[0] && !ovf_ev) |=> !irq_flags[0];
	endproperty
	a_ack: assert property (p_ack) else $error("ack did not clear"); // R10

	// ==========================================
	// reserved bits and reset
	property p_mask_rsvd;
		@(posedge clk) disable iff (rst) (psel && !penable && sel_mask) |=> (prdata[31:3] == 29'h0);
	endproperty
	a_mask_rsvd: assert property (p_mask_rsvd) else $error("mask upper bits not zero"); // R3
	property p_flags_rsvd;
		@(posedge clk) disable iff (rst) (psel && !penable && sel_flags) |=> (prdata[31:3] == 29'h0);
	endproperty
	a_flags_rsvd: assert property (p_flags_rsvd) else $error("flag upper bits not zero"); // R3
	property p_mask_reset;
		@(posedge clk) $fell(rst) |-> (irq_mask == tmc_pkg::IRQ_RESET);
	endproperty
	a_mask_reset: assert property (p_mask_reset) else $error("mask not zero after reset"); // R16

	// ==========================================
	// flag setting
	property p_set_o;
		@(posedge clk) disable iff (rst) ovf_ev |=> irq_flags[0];
	endproperty
	a_set_o: assert property (p_set_o) else $error("overflow flag not set"); // R9

	// ==========================================
	// request follows flag, mask and global enable
	property p_req_flag_b;
		@(posedge clk) disable iff (rst) irq_req[2] |-> irq_flags[2];
	endproperty
	a_req_flag_b: assert property (p_req_flag_b) else $error("req b without flag"); // R12
	property p_req_flag_a;
		@(posedge clk) disable iff (rst) irq_req[1] |-> irq_flags[1];
	endproperty
	a_req_flag_a: assert property (p_req_flag_a) else $error("req a without flag"); // R12
	property p_req_flag_o;
		@(posedge clk) disable iff (rst) irq_req[0] |-> irq_flags[0];
	endproperty
	a_req_flag_o: assert property (p_req_flag_o) else $error("overflow req without flag"); // R12
	property p_req_on_b;
		@(posedge clk) disable iff (rst)
			(irq_flags[2] && $past(irq_mask[2]) && $past(global_irq_en)) |-> irq_req[2];
	endproperty
	a_req_on_b: assert property (p_req_on_b) else $error("req b missing"); // R4
	property p_req_on_a;
		@(posedge clk) disable iff (rst)
			(irq_flags[1] && $past(irq_mask[1]) && $past(global_irq_en)) |-> irq_req[1];
	endproperty
	a_req_on_a: assert property (p_req_on_a) else $error("req a missing"); // R5
	property p_req_on_o;
		@(posedge clk) disable iff (rst)
			(irq_flags[0] && $past(irq_mask[0]) && $past(global_irq_en)) |-> irq_req[0];
	endproperty
	a_req_on_o: assert property (p_req_on_o) else $error("overflow req missing"); // R6

	// ==========================================
	// match and force effects on outputs and flags
	property p_toggle_a;
		@(posedge clk) disable iff (rst) ev_a |-> (out_a != $past(out_a));
	endproperty
	a_toggle_a: assert property (p_toggle_a) else $error("match a did not toggle"); // R1
	property p_toggle_b;
		@(posedge clk) disable iff (rst) ev_b |-> (out_b != $past(out_b));
	endproperty
	a_toggle_b: assert property (p_toggle_b) else $error("match b did not toggle"); // R2
	property p_force_a;
		@(posedge clk) disable iff (rst) (force_a && !timer_tick) |=> (out_a != $past(out_a));
	endproperty
	a_force_a: assert property (p_force_a) else $error("force a did not toggle"); // R13
	property p_force_b;
		@(posedge clk) disable iff (rst) (force_b && !timer_tick) |=> (out_b != $past(out_b));
	endproperty
	a_force_b: assert property (p_force_b) else $error("force b did not toggle"); // R13
	property p_force_noflag_a;
		@(posedge clk) disable iff (rst) (force_a && !irq_flags[1] && !ev_a) |=> !irq_flags[1];
	endproperty
	a_force_noflag_a: assert property (p_force_noflag_a) else $error("force a set flag"); // R13
	property p_force_noflag_b;
		@(posedge clk) disable iff (rst) (force_b && !irq_flags[2] && !ev_b) |=> !irq_flags[2];
	endproperty
	a_force_noflag_b: assert property (p_force_noflag_b) else $error("force b set flag"); // R13

	// ==========================================
	// counter write and bus answer
	property p_cnt_load;
		@(posedge clk) disable iff (rst) cnt_wr |=> (counter_value == $past(pwdata[CW-1:0]));
	endproperty
	a_cnt_load: assert property (p_cnt_load) else $error("counter write lost"); // R14
	property p_ready_on;
		@(posedge clk) disable iff (rst) (psel && !penable) |=> pready;
	endproperty
	a_ready_on: assert property (p_ready_on) else $error("no ready after setup");
	property p_ready_pulse;
		@(posedge clk) disable iff (rst) pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
endmodule : tmc_timer
